/* common/pwc_map.svh */
`ifndef PWC_MAP_SVH
`define PWC_MAP_SVH
// Register byte offsets
`define PWC_OFS_IRQ_EN 12'hd60
`define PWC_OFS_STATUS 12'hd64
`define PWC_OFS_CONTROL 12'hd68
`define PWC_OFS_MV_READ 12'hd6c
`define PWC_OFS_MV_WRITE 12'hd70
`define PWC_OFS_SUB_ONE 12'hd74
`define PWC_OFS_SUB_TWO 12'hd78
`define PWC_OFS_WIN_CMD 12'hd7c
// Writable bits of each register
`define PWC_MASK_IRQ_EN 32'h0000_01ff
`define PWC_MASK_STATUS 32'h0700_0000
`define PWC_MASK_CONTROL 32'h0f00_0000
`define PWC_MASK_WIN_CMD 32'he7e7_e7e7
// Reset values
`define PWC_RST_IRQ_EN 32'h0000_0000
`define PWC_RST_STATUS 32'h0000_0000
`define PWC_RST_CONTROL 32'h0800_0000
`define PWC_RST_MV 32'h0000_0000
`define PWC_RST_SUB 32'h0000_0000
`define PWC_RST_WIN_CMD 32'h0000_0000
// Field positions (bit 0 is the least significant)
`define PWC_BIT_IRQ_EN 8
`define PWC_POS_MAX_RETRY 0
`define PWC_BIT_RETRY_ERR 26
`define PWC_BIT_TGT_ABORT 25
`define PWC_BIT_INI_ABORT 24
`define PWC_BIT_EXT_RESET 27
`define PWC_BIT_CFG_MSB 26
`define PWC_BIT_POST_DIS 25
`define PWC_BIT_LAT_DIS 24
`define PWC_POS_W1_MASK 24
`define PWC_POS_W1_VALUE 16
`define PWC_POS_W2_MASK 8
`define PWC_POS_W2_VALUE 0
`define PWC_POS_SUB_START 16
`define PWC_POS_SUB_STOP 0
`define PWC_POS_W1_FIELD 24
`define PWC_POS_W2_FIELD 16
`define PWC_POS_S1_FIELD 8
`define PWC_POS_S2_FIELD 0
// Inside an 8-bit command/control field
`define PWC_FLD_CMD 5
`define PWC_FLD_REMAP 2
`define PWC_FLD_INI_POST 1
`define PWC_FLD_APPLY 0
// Retry limit values that mean no limit
`define PWC_RETRY_NONE_LO 8'h00
`define PWC_RETRY_NONE_HI 8'hff
`define PWC_RESP_OKAY 2'h0
`define PWC_RESP_SLVERR 2'h2
`endif

/* common/pwc_pkg.sv */
package pwc_pkg;
    // Address to translate, with the main-window decode already done
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic win_one_hit;
        logic win_two_hit;
        logic write;
        logic config_access;
    } pwc_xlate_req_type;
    // Translated address and command for the PCI initiator
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic init_post_disable;
        logic sub_one_hit;
        logic sub_two_hit;
    } pwc_xlate_rsp_type;
    // One-cycle event pulses from the PCI initiator core
    typedef struct packed {
        logic retry;
        logic target_abort;
        logic initiator_abort;
        logic done;
    } pwc_init_evt_type;
endpackage : pwc_pkg

/* testbench/pwc_far.sv */
`timescale 1ns/100ps
module pwc_far
(
    input wire logic core_clk_i,
    output pwc_pkg::pwc_init_evt_type evt_o,
    output pwc_pkg::pwc_xlate_req_type req_o
);
import pwc_pkg::*;
initial
begin
    evt_o = '0;
    req_o = '0;
end
// ====
// Core events last one cycle
task automatic pulse(input pwc_init_evt_type e);
    @(posedge core_clk_i);
    evt_o <= e;
    @(posedge core_clk_i);
    evt_o <= '0;
endtask : pulse
// Released address is inverted so a stale value never matches
task automatic send(input pwc_xlate_req_type r);
    @(posedge core_clk_i);
    req_o <= r;
    @(posedge core_clk_i);
    req_o <= '{addr: ~r.addr, default: 1'b0};
endtask : send
endmodule : pwc_far

/* testbench/pwc_top_bench.sv */
`timescale 1ns/100ps
module pwc_top_bench;
import pwc_pkg::*;
logic core_clk_i, reset_i, s_axi_awvalid_i, s_axi_awready_o;
logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
logic init_retry_abort_o, ext_pci_reset_o, posting_disable_o;
logic latency_rule_disable_o, error_irq_o;
logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
logic [3:0] s_axi_wstrb_i;
logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
pwc_init_evt_type init_evt_i;
pwc_xlate_req_type xlate_req_i;
pwc_xlate_rsp_type xlate_rsp_o;
int failures, checks_done;
pwc_top uut (.*);
pwc_far far (.core_clk_i, .evt_o(init_evt_i), .req_o(xlate_req_i));
// ====
// Checks and bus cycles
task final_report;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask : final_report
task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
endtask : chk
task automatic bound(input int n);
    if (n >= 50)
    begin
        failures++;
        $display("MISMATCH handshake expected answer seen none");
        final_report;
    end
endtask : bound
task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    n = 0;
    do
    begin
        @(posedge core_clk_i);
        n++;
        if (s_axi_awready_o)
            s_axi_awvalid_i <= 1'b0;
        if (s_axi_wready_o)
            s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1 && n < 50);
    s_axi_bready_i <= 1'b0;
    bound(n);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
endtask : wr
task automatic rd(input logic [11:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    n = 0;
    do
    begin
        @(posedge core_clk_i);
        n++;
        if (s_axi_arready_o)
            s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1 && n < 50);
    s_axi_rready_i <= 1'b0;
    bound(n);
    chk("rdata", ed, s_axi_rdata_o);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
endtask : rd
task automatic pins(input logic [2:0] e);
    repeat (2) @(negedge core_clk_i);
    chk("pins", {29'h0, e}, {29'h0, ext_pci_reset_o, posting_disable_o,
        latency_rule_disable_o});
endtask : pins
task automatic rt(input logic [3:0] e, input logic ea);
    far.pulse(e);
    @(negedge core_clk_i);
    chk("abort", {31'h0, ea}, {31'h0, init_retry_abort_o});
endtask : rt
task automatic xchk(input logic [36:0] rq, input logic [31:0] ea,
    input logic [5:0] ec);
    far.send(rq);
    @(negedge core_clk_i);
    chk("xvalid", 32'h1, {31'h0, xlate_rsp_o.valid});
    chk("xaddr", ea, xlate_rsp_o.addr);
    chk("xcmd", {26'h0, ec}, {26'h0, xlate_rsp_o.cmd,
        xlate_rsp_o.sub_one_hit, xlate_rsp_o.sub_two_hit});
endtask : xchk
// ====
// Scenarios
task automatic t_reset;
    logic [11:0] ofs [6] = '{12'hd60, 12'hd64, 12'hd6c, 12'hd74, 12'hd78,
        12'hd7c};
    rd(12'hd68, 32'h0800_0000, 2'h0);
    pins(3'b100);
    foreach (ofs[i])
        rd(ofs[i], 32'h0, 2'h0);
    wr(12'h004, 32'hffff_ffff, 2'h2);
    rd(12'h004, 32'h0, 2'h2);
    $display("reset test done");
endtask : t_reset
task automatic t_ctrl;
    logic [31:0] v;
    wr(12'hd68, 32'hffff_ffff, 2'h0);
    rd(12'hd68, 32'h0f00_0000, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
        v = 32'h0100_0000 << i;
        wr(12'hd68, v, 2'h0);
        pins({v[27], v[25], v[24]});
    end
    $display("control test done");
endtask : t_ctrl
task automatic t_status;
    wr(12'hd60, 32'h0000_0102, 2'h0);
    far.pulse(4'b0100);
    rd(12'hd64, 32'h0200_0000, 2'h0);
    chk("irq", 32'h1, {31'h0, error_irq_o});
    wr(12'hd64, 32'h0, 2'h0);
    rd(12'hd64, 32'h0200_0000, 2'h0);
    far.pulse(4'b0010);
    wr(12'hd68, 32'h0800_0000, 2'h0);
    rd(12'hd64, 32'h0300_0000, 2'h0);
    wr(12'hd64, 32'h0200_0000, 2'h0);
    rd(12'hd64, 32'h0100_0000, 2'h0);
    wr(12'hd64, 32'hffff_ffff, 2'h0);
    rd(12'hd64, 32'h0, 2'h0);
    chk("irq", 32'h0, {31'h0, error_irq_o});
    wr(12'hd60, 32'h0000_0002, 2'h0);
    far.pulse(4'b0010);
    rd(12'hd64, 32'h0100_0000, 2'h0);
    chk("irq", 32'h0, {31'h0, error_irq_o});
    wr(12'hd64, 32'hffff_ffff, 2'h0);
    $display("status test done");
endtask : t_status
task automatic t_retry;
    logic [7:0] lim [2] = '{8'h00, 8'hff};
    rt(4'b1000, 1'b0);
    rt(4'b1000, 1'b1);
    rd(12'hd64, 32'h0400_0000, 2'h0);
    wr(12'hd64, 32'hffff_ffff, 2'h0);
    rt(4'b1000, 1'b0);
    rt(4'b0001, 1'b0);
    rt(4'b1000, 1'b0);
    rt(4'b1000, 1'b1);
    wr(12'hd64, 32'hffff_ffff, 2'h0);
    foreach (lim[i])
    begin
        wr(12'hd60, {24'h0, lim[i]}, 2'h0);
        repeat (3) rt(4'b1000, 1'b0);
        rt(4'b0001, 1'b0);
        rd(12'hd64, 32'h0, 2'h0);
    end
    wr(12'hd60, 32'h0000_0001, 2'h0);
    rt(4'b1000, 1'b1);
    $display("retry test done");
endtask : t_retry
task automatic t_xlate;
    wr(12'hd70, 32'hf0a5_0f3c, 2'h0);
    rd(12'hd6c, 32'hf0a5_0f3c, 2'h0);
    rd(12'hd70, 32'h0, 2'h0);
    wr(12'hd6c, 32'h0, 2'h0);
    rd(12'hd6c, 32'hf0a5_0f3c, 2'h0);
    // Settings written before any request reaches the core
    wr(12'hd68, 32'h0, 2'h0);
    wr(12'hd7c, 32'h6120_e140, 2'h0);
    xchk({1'b1, 32'h1234_5678, 4'b1010}, 32'ha234_5678, 6'h1c);
    xchk({1'b1, 32'h1234_5678, 4'b0100}, 32'h1234_5678, 6'h08);
    xchk({1'b1, 32'h5555_aaaa, 4'b0010}, 32'h5555_aaaa, 6'h04);
    wr(12'hd7c, 32'h6121_e140, 2'h0);
    xchk({1'b1, 32'h1234_5678, 4'b0100}, 32'h1c34_5678, 6'h08);
    xchk({1'b1, 32'h0034_5678, 4'b0101}, 32'h0c34_5678, 6'h08);
    wr(12'hd68, 32'h0400_0000, 2'h0);
    xchk({1'b1, 32'h0034_5678, 4'b0101}, 32'h8c34_5678, 6'h08);
    xchk({1'b1, 32'h0000_0010, 4'b0001}, 32'h8000_0010, 6'h00);
    wr(12'hd68, 32'h0, 2'h0);
    // Only the low byte lane may land
    s_axi_wstrb_i <= 4'h1;
    wr(12'hd74, 32'hffff_ff55, 2'h0);
    s_axi_wstrb_i <= 4'hf;
    rd(12'hd74, 32'h0000_0055, 2'h0);
    wr(12'hd74, 32'h1200_1300, 2'h0);
    wr(12'hd78, 32'h4000_5000, 2'h0);
    xchk({1'b1, 32'h1234_5678, 4'b1010}, 32'ha234_5678, 6'h3e);
    xchk({1'b1, 32'h1200_0000, 4'b1000}, 32'ha200_0000, 6'h3a);
    xchk({1'b1, 32'h1300_0000, 4'b1000}, 32'ha300_0000, 6'h18);
    xchk({1'b1, 32'h4100_0000, 4'b0100}, 32'h4100_0000, 6'h11);
    xchk({1'b1, 32'h1250_0000, 4'b0110}, 32'h1c50_0000, 6'h3e);
    // Remap, initiator post disable and overlay together on window one
    wr(12'hd7c, 32'h6700_0000, 2'h0);
    xchk({1'b1, 32'h0abc_de15, 4'b1010}, 32'ha000_79b5, 6'h1c);
    chk("xpost", 32'h1, {31'h0, xlate_rsp_o.init_post_disable});
    $display("translate test done");
endtask : t_xlate
initial
begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
end
initial
begin
    reset_i = 1'b1;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 3'h0;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'h0;
    s_axi_awaddr_i = 12'h000;
    s_axi_araddr_i = 12'h000;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_ctrl;
    t_status;
    t_retry;
    t_xlate;
    final_report;
end
endmodule : pwc_top_bench

/* testbench/pwc_top_properties.sv */
`timescale 1ns/100ps
`include "pwc_map.svh"
module pwc_top_properties
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire pwc_pkg::pwc_init_evt_type init_evt_i,
    input wire logic init_retry_abort_o,
    input wire pwc_pkg::pwc_xlate_req_type xlate_req_i,
    input wire pwc_pkg::pwc_xlate_rsp_type xlate_rsp_o,
    input wire logic ext_pci_reset_o,
    input wire logic posting_disable_o,
    input wire logic latency_rule_disable_o,
    input wire logic error_irq_o
);
import pwc_pkg::*;
// ====
// Shadow of the control and enable bits, taken at the write response
logic [11:0] wa_ff, nxt_wa;
logic [31:0] wd_ff, nxt_wd;
logic [3:0] ctl_ff, nxt_ctl;
logic ie_ff, nxt_ie;
logic upd;
always_comb
begin
    upd = s_axi_bvalid_o && s_axi_bready_i && s_axi_bresp_o == 2'h0;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    nxt_ctl = ctl_ff;
    nxt_ie = ie_ff;
    if (s_axi_awvalid_i && s_axi_awready_o)
        nxt_wa = s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o)
        nxt_wd = s_axi_wdata_i;
    if (upd && wa_ff == `PWC_OFS_CONTROL)
        nxt_ctl = wd_ff[27:24];
    if (upd && wa_ff == `PWC_OFS_IRQ_EN)
        nxt_ie = wd_ff[8];
end
always_ff @(posedge core_clk_i or posedge reset_i)
begin
    if (reset_i)
    begin
        wa_ff <= 12'h000;
        wd_ff <= 32'h0000_0000;
        ctl_ff <= 4'h8;
        ie_ff <= 1'b0;
    end
    else
    begin
        wa_ff <= nxt_wa;
        wd_ff <= nxt_wd;
        ctl_ff <= nxt_ctl;
        ie_ff <= nxt_ie;
    end
end
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (reset_i);
AST_EXT_RST_INIT: assert property ($fell(reset_i)
    |-> ext_pci_reset_o)
    else $error("external reset not asserted after reset");
AST_EXT_RST_CTL: assert property ((upd && wa_ff == `PWC_OFS_CONTROL)
    |=> ext_pci_reset_o == wd_ff[27]) else $error("external reset pin wrong");
AST_POST_DIS: assert property ((upd && wa_ff == `PWC_OFS_CONTROL)
    |=> posting_disable_o == wd_ff[25]) else $error("posting pin wrong");
AST_LAT_DIS: assert property ((upd && wa_ff == `PWC_OFS_CONTROL)
    |=> latency_rule_disable_o == wd_ff[24]) else $error("latency pin wrong");
AST_CFG_MSB: assert property ((xlate_req_i.valid && ctl_ff[2]
    && xlate_req_i.config_access) |=> xlate_rsp_o.addr[31])
    else $error("config msb not forced");
AST_NO_HIT_PASS: assert property ((xlate_req_i.valid
    && !xlate_req_i.win_one_hit
    && !xlate_req_i.win_two_hit && !(ctl_ff[2] && xlate_req_i.config_access))
    |=> xlate_rsp_o.addr == $past(xlate_req_i.addr)
    && xlate_rsp_o.cmd == {3'b000, $past(xlate_req_i.write)})
    else $error("unhit address altered");
AST_RSP_CMD_LSB: assert property (xlate_req_i.valid
    |=> xlate_rsp_o.valid
    && xlate_rsp_o.cmd[0] == $past(xlate_req_i.write))
    else $error("translate response wrong");
AST_IRQ_GATED: assert property (error_irq_o
    |-> ie_ff || $past(ie_ff)
    || (upd && wa_ff == `PWC_OFS_IRQ_EN && wd_ff[8]))
    else $error("interrupt while disabled");
AST_ABORT_CAUSE: assert property (init_retry_abort_o |->
    $past(init_evt_i.retry) && !$past(init_evt_i.done))
    else $error("abort without retry");
endmodule : pwc_top_properties
bind pwc_top pwc_top_properties chk (.*);

/* verilog/pwc_top.sv */
`timescale 1ns/100ps
`include "pwc_map.svh"
// Function
// - Max retries sets retry flag, W1C
// - Target abort sets its flag, W1C
// - Initiator abort sets its flag, W1C
// - External reset bit resets to one
// - External reset leaves core state alone
// - Config MSB forced on config accesses
// - Otherwise mask/value decides address MSB
// - Posting disable bit drives target posting
// - Latency disable blocks 16/8 retries
// - Mask ones select top address bits
// - Value bits replace masked top bits
// - Window two has own mask/value
// - Mask/value read and write split
// - Overlay only when window enables it
// - Subwindow start compare greater-or-equal
// - Subwindow stop compare less-than
// - Subwindow settings override main window
// - Both subwindows checked on any hit
// - Error interrupt only when enabled
// - Retry limit 0 or FF means unlimited
module pwc_top
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [11:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [11:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire pwc_pkg::pwc_init_evt_type init_evt_i,
    output logic init_retry_abort_o,
    input wire pwc_pkg::pwc_xlate_req_type xlate_req_i,
    output pwc_pkg::pwc_xlate_rsp_type xlate_rsp_o,
    output logic ext_pci_reset_o,
    output logic posting_disable_o,
    output logic latency_rule_disable_o,
    output logic error_irq_o
);
    import pwc_pkg::*;

    // ==========================================================
    // Register bus slave
    // ==========================================================
    logic aw_full_ff, nxt_aw_full;
    logic w_full_ff, nxt_w_full;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic [31:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic do_write;
    logic wr_hit;
    logic [31:0] byte_mask;
    logic [31:0] rd_value;
    logic rd_hit;

    logic [31:0] irq_en_ff, nxt_irq_en;
    logic [31:0] status_ff, nxt_status;
    logic [31:0] control_ff, nxt_control;
    logic [31:0] mv_ff, nxt_mv;
    logic [31:0] sub_one_ff, nxt_sub_one;
    logic [31:0] sub_two_ff, nxt_sub_two;
    logic [31:0] win_cmd_ff, nxt_win_cmd;

    assign s_axi_awready_o = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready_o = !w_full_ff && !bvalid_ff;
    assign s_axi_arready_o = !rvalid_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;

    // Address and data are held apart, so either may arrive first
    assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;

    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_lane
            assign byte_mask[b*8 +: 8] = {8{w_strb_ff[b]}};
        end
    endgenerate

    always_comb
    begin
        nxt_aw_full = aw_full_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_full = w_full_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            nxt_aw_full = 1'b1;
            nxt_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            nxt_w_full = 1'b1;
            nxt_w_data = s_axi_wdata_i;
            nxt_w_strb = s_axi_wstrb_i;
        end
        if (do_write)
        begin
            nxt_aw_full = 1'b0;
            nxt_w_full = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_hit ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
        end
        else if (bvalid_ff && s_axi_bready_i)
        begin
            nxt_bvalid = 1'b0;
        end
    end

    // Read decode; write-only and unmapped words read as zero
    always_comb
    begin
        rd_hit = 1'b1;
        rd_value = 32'h0000_0000;
        if (s_axi_araddr_i == `PWC_OFS_IRQ_EN)
            rd_value = irq_en_ff;
        else if (s_axi_araddr_i == `PWC_OFS_STATUS)
            rd_value = status_ff & `PWC_MASK_STATUS;
        else if (s_axi_araddr_i == `PWC_OFS_CONTROL)
            rd_value = control_ff;
        else if (s_axi_araddr_i == `PWC_OFS_MV_READ)
            rd_value = mv_ff;
        else if (s_axi_araddr_i == `PWC_OFS_MV_WRITE)
            rd_value = 32'h0000_0000;
        else if (s_axi_araddr_i == `PWC_OFS_SUB_ONE)
            rd_value = sub_one_ff;
        else if (s_axi_araddr_i == `PWC_OFS_SUB_TWO)
            rd_value = sub_two_ff;
        else if (s_axi_araddr_i == `PWC_OFS_WIN_CMD)
            rd_value = win_cmd_ff;
        else
            rd_hit = 1'b0;
    end

    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_value;
            nxt_rresp = rd_hit ? `PWC_RESP_OKAY : `PWC_RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready_i)
        begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            aw_full_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_full_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end
        else
        begin
            aw_full_ff <= nxt_aw_full;
            aw_addr_ff <= nxt_aw_addr;
            w_full_ff <= nxt_w_full;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ==========================================================
    // Registers and error flags
    // ==========================================================
    logic [7:0] retry_cnt_ff, nxt_retry_cnt;
    logic retry_abort_ff, nxt_retry_abort;
    logic [7:0] retry_limit;
    logic limit_on;
    logic [31:0] set_bits;
    logic [31:0] wbits;

    assign retry_limit = irq_en_ff[`PWC_POS_MAX_RETRY +: 8];
    // zero or all ones disables the abort
    assign limit_on = (retry_limit != `PWC_RETRY_NONE_LO) &&
                      (retry_limit != `PWC_RETRY_NONE_HI);
    assign wbits = w_data_ff & byte_mask;

    always_comb
    begin
        nxt_retry_cnt = retry_cnt_ff;
        nxt_retry_abort = 1'b0;
        if (init_evt_i.done)
        begin
            nxt_retry_cnt = 8'h00;
        end
        else if (init_evt_i.retry)
        begin
            nxt_retry_cnt = retry_cnt_ff + 8'h01;
            if (limit_on && (retry_cnt_ff + 8'h01 == retry_limit))
            begin
                nxt_retry_abort = 1'b1;
                nxt_retry_cnt = 8'h00;
            end
        end
    end

    always_comb
    begin
        set_bits = 32'h0000_0000;
        set_bits[`PWC_BIT_RETRY_ERR] = nxt_retry_abort;
        set_bits[`PWC_BIT_TGT_ABORT] = init_evt_i.target_abort;
        set_bits[`PWC_BIT_INI_ABORT] = init_evt_i.initiator_abort;
    end

    always_comb
    begin
        nxt_irq_en = irq_en_ff;
        nxt_control = control_ff;
        nxt_mv = mv_ff;
        nxt_sub_one = sub_one_ff;
        nxt_sub_two = sub_two_ff;
        nxt_win_cmd = win_cmd_ff;
        nxt_status = status_ff;
        wr_hit = 1'b1;
        if (aw_addr_ff == `PWC_OFS_IRQ_EN)
            nxt_irq_en = (irq_en_ff & ~(byte_mask & `PWC_MASK_IRQ_EN)) |
                         (wbits & `PWC_MASK_IRQ_EN);
        else if (aw_addr_ff == `PWC_OFS_STATUS)
            nxt_status = status_ff;
        else if (aw_addr_ff == `PWC_OFS_CONTROL)
            nxt_control = (control_ff & ~(byte_mask & `PWC_MASK_CONTROL)) |
                          (wbits & `PWC_MASK_CONTROL);
        else if (aw_addr_ff == `PWC_OFS_MV_READ)
            nxt_mv = mv_ff;
        else if (aw_addr_ff == `PWC_OFS_MV_WRITE)
            nxt_mv = (mv_ff & ~byte_mask) | wbits;
        else if (aw_addr_ff == `PWC_OFS_SUB_ONE)
            nxt_sub_one = (sub_one_ff & ~byte_mask) | wbits;
        else if (aw_addr_ff == `PWC_OFS_SUB_TWO)
            nxt_sub_two = (sub_two_ff & ~byte_mask) | wbits;
        else if (aw_addr_ff == `PWC_OFS_WIN_CMD)
            nxt_win_cmd = (win_cmd_ff & ~(byte_mask & `PWC_MASK_WIN_CMD)) |
                          (wbits & `PWC_MASK_WIN_CMD);
        else
            wr_hit = 1'b0;
        if (!do_write)
        begin
            nxt_irq_en = irq_en_ff;
            nxt_control = control_ff;
            nxt_mv = mv_ff;
            nxt_sub_one = sub_one_ff;
            nxt_sub_two = sub_two_ff;
            nxt_win_cmd = win_cmd_ff;
        end
        if (do_write && aw_addr_ff == `PWC_OFS_STATUS)
            nxt_status = status_ff & ~(wbits & `PWC_MASK_STATUS);
        // A new event wins over a clear in the same cycle
        nxt_status = nxt_status | set_bits;
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            irq_en_ff <= `PWC_RST_IRQ_EN;
            status_ff <= `PWC_RST_STATUS;
            control_ff <= `PWC_RST_CONTROL;
            mv_ff <= `PWC_RST_MV;
            sub_one_ff <= `PWC_RST_SUB;
            sub_two_ff <= `PWC_RST_SUB;
            win_cmd_ff <= `PWC_RST_WIN_CMD;
            retry_cnt_ff <= 8'h00;
            retry_abort_ff <= 1'b0;
        end
        else
        begin
            irq_en_ff <= nxt_irq_en;
            status_ff <= nxt_status;
            control_ff <= nxt_control;
            mv_ff <= nxt_mv;
            sub_one_ff <= nxt_sub_one;
            sub_two_ff <= nxt_sub_two;
            win_cmd_ff <= nxt_win_cmd;
            retry_cnt_ff <= nxt_retry_cnt;
            retry_abort_ff <= nxt_retry_abort;
        end
    end

    assign init_retry_abort_o = retry_abort_ff;
    // pin only; no internal state is reset by it
    assign ext_pci_reset_o = control_ff[`PWC_BIT_EXT_RESET];
    assign posting_disable_o = control_ff[`PWC_BIT_POST_DIS];
    assign latency_rule_disable_o = control_ff[`PWC_BIT_LAT_DIS];
    assign error_irq_o = irq_en_ff[`PWC_BIT_IRQ_EN] &&
                         (|(status_ff & `PWC_MASK_STATUS));

    // ==========================================================
    // Initiator address translation
    // ==========================================================
    pwc_xlate_rsp_type rsp_ff, nxt_rsp;
    logic [15:0] addr_hi;
    logic sub_one_in, sub_two_in;
    logic [7:0] field;
    logic [7:0] ov_mask, ov_value;
    logic [31:0] remapped;
    logic main_hit;

    assign addr_hi = xlate_req_i.addr[31:16];
    assign main_hit = xlate_req_i.win_one_hit || xlate_req_i.win_two_hit;
    assign sub_one_in = (addr_hi >= sub_one_ff[`PWC_POS_SUB_START +: 16]) &&
                        (addr_hi < sub_one_ff[`PWC_POS_SUB_STOP +: 16]);
    assign sub_two_in = (addr_hi >= sub_two_ff[`PWC_POS_SUB_START +: 16]) &&
                        (addr_hi < sub_two_ff[`PWC_POS_SUB_STOP +: 16]);

    always_comb
    begin
        field = 8'h00;
        ov_mask = 8'h00;
        ov_value = 8'h00;
        // Window one wins if the decoder flags both
        if (xlate_req_i.win_one_hit)
        begin
            field = win_cmd_ff[`PWC_POS_W1_FIELD +: 8];
            ov_mask = mv_ff[`PWC_POS_W1_MASK +: 8];
            ov_value = mv_ff[`PWC_POS_W1_VALUE +: 8];
        end
        else if (xlate_req_i.win_two_hit)
        begin
            field = win_cmd_ff[`PWC_POS_W2_FIELD +: 8];
            ov_mask = mv_ff[`PWC_POS_W2_MASK +: 8];
            ov_value = mv_ff[`PWC_POS_W2_VALUE +: 8];
        end
        // both subwindows checked, first one wins
        if (main_hit && sub_one_in)
            field = win_cmd_ff[`PWC_POS_S1_FIELD +: 8];
        else if (main_hit && sub_two_in)
            field = win_cmd_ff[`PWC_POS_S2_FIELD +: 8];
    end

    always_comb
    begin
        nxt_rsp = rsp_ff;
        nxt_rsp.valid = xlate_req_i.valid;
        remapped = xlate_req_i.addr;
        if (field[`PWC_FLD_REMAP])
            remapped = {16'h0000, xlate_req_i.addr[22:12],
                        xlate_req_i.addr[4:0]};
        if (field[`PWC_FLD_APPLY])
            remapped[31:24] = (remapped[31:24] & ~ov_mask) |
                              (ov_value & ov_mask);
        if (control_ff[`PWC_BIT_CFG_MSB] && xlate_req_i.config_access)
            remapped[31] = 1'b1;
        if (xlate_req_i.valid)
        begin
            nxt_rsp.addr = remapped;
            nxt_rsp.cmd = {field[`PWC_FLD_CMD +: 3], xlate_req_i.write};
            nxt_rsp.init_post_disable = field[`PWC_FLD_INI_POST];
            nxt_rsp.sub_one_hit = main_hit && sub_one_in;
            nxt_rsp.sub_two_hit = main_hit && !sub_one_in && sub_two_in;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rsp_ff <= '0;
        else
            rsp_ff <= nxt_rsp;
    end

    assign xlate_rsp_o = rsp_ff;

endmodule : pwc_top
